//--- hw/rbrc_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit classic wishbone slave with byte addresses
`ifndef RBRC_REGS_SVH
`define RBRC_REGS_SVH
// byte offsets
`define RBRC_OFS_CTRL      8'h00
`define RBRC_OFS_CMD       8'h04
`define RBRC_OFS_CAP       8'h08
`define RBRC_OFS_COUNT     8'h0c
`define RBRC_OFS_FREE      8'h10
`define RBRC_OFS_RSVD      8'h14
`define RBRC_OFS_STAT      8'h18
`define RBRC_OFS_DUMPV     8'h1c
`define RBRC_OFS_DUMPT     8'h20
// control fields
`define RBRC_CTRL_FEED_LSB 0
`define RBRC_CTRL_FEED_MSB 1
`define RBRC_CTRL_FILL     2
`define RBRC_CTRL_STYLE    3
`define RBRC_CTRL_AUTOOFF  4
`define RBRC_CTRL_ATSR     5
`define RBRC_CTRL_TRIGWAIT 6
`define RBRC_CTRL_MASK     32'h0000007f
`define RBRC_CTRL_RST      32'h00000000
// command bits, write one to fire
`define RBRC_CMD_WIPE      0
`define RBRC_CMD_DROP      1
`define RBRC_CMD_INIT      2
`define RBRC_CMD_READ      3
`define RBRC_CMD_MEAS      4
`define RBRC_CMD_ABORT     5
`define RBRC_CMD_BUSCLR    6
`define RBRC_CMD_TSRST     7
`define RBRC_CMD_OUTON     8
`define RBRC_CMD_OUTOFF    9
`define RBRC_CMD_DUMP      10
// status bits
`define RBRC_STAT_IDLE     0
`define RBRC_STAT_ARMED    1
`define RBRC_STAT_OUTON    2
`define RBRC_STAT_PEND     3
`define RBRC_STAT_REFUSED  4
// capacity in reading arrays
`define RBRC_CAP_MIN       12'h001
`define RBRC_CAP_MAX       12'h9c4
`define RBRC_CAP_RST       12'h064
`define RBRC_BYTES_SHIFT   3
// timestamp tick
`define RBRC_TICK_NS       1000
`define RBRC_CLK_NS        8
`define RBRC_TICK_CYC      (`RBRC_TICK_NS / `RBRC_CLK_NS)
`endif

//--- hw/rbrc_pkg.sv
// types shared by the reading buffer and run control design
// assumes the constants header is included where offsets are needed
package rbrc_pkg;
    typedef enum logic [1:0] {
        RBRC_FEED_RAW    = 2'h0,
        RBRC_FEED_MATH   = 2'h1,
        RBRC_FEED_SECOND = 2'h2
    } rbrc_feed_t;

    typedef enum logic [1:0] {
        RBRC_S_IDLE = 2'h0,
        RBRC_S_SRC  = 2'h1,
        RBRC_S_MEAS = 2'h2
    } rbrc_run_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] value;
    } rbrc_rdg_t;

    typedef struct packed {
        logic [31:0] value;
        logic [31:0] stamp;
    } rbrc_entry_t;
endpackage : rbrc_pkg

//--- hw/rbrc_store.sv
// reading store: one write port, one read port with registered data
// assumes writer and reader share clk
`timescale 1ns/100ps
module rbrc_store
    import rbrc_pkg::*;
(
    // clock
    input  wire logic        clk,
    // write side
    input  wire logic        wr_en,
    input  wire logic [11:0] wr_addr,
    input  wire rbrc_entry_t wr_data,
    // read side
    input  wire logic [11:0] rd_addr,
    output rbrc_entry_t      rd_data
);
    rbrc_entry_t mem [0:2499];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule : rbrc_store

//--- hw/rbrc_tstamp.sv
// absolute timestamp counter in microseconds
// assumes clk at the rate that the tick constants name
`timescale 1ns/100ps
`include "rbrc_regs.svh"
module rbrc_tstamp
    import rbrc_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // control
    input  wire logic        zero_i,
    // time
    output logic      [31:0] stamp_o
);
    logic [7:0] pre_r;

    always_ff @(posedge clk) begin
        if (sys_rst || zero_i) begin
            pre_r   <= 8'h00;
            stamp_o <= 32'h00000000;
        end else if (pre_r == 8'(`RBRC_TICK_CYC - 1)) begin
            pre_r   <= 8'h00;
            stamp_o <= stamp_o + 32'h00000001;
        end else begin
            pre_r   <= pre_r + 8'h01;
        end
    end
endmodule : rbrc_tstamp

//--- hw/rbrc_top.sv
// reading buffer and run control with a classic wishbone slave
// assumes feeds, meas_done_i and run_ops_i come from logic on clk;
// the trigger input is a pin and is synchronised here
// Functional notes
// R1 - a dump rewinds the read pointer; reads then return every stored reading
// R2 - wipe discards all stored readings and zeroes the count
// R3 - without a wipe a new storage run overwrites older readings
// R4 - memory usage gives free bytes, then bytes reserved for readings
// R5 - capacity is 1 to 2500 arrays, 100 after reset
// R6 - stored count register shows readings held in the buffer
// R7 - origin selects raw, math result or second stage result readings
// R8 - origin selection cannot change while storage is armed
// R9 - fill once arms storage when the run leaves idle
// R10 - storage stops and disarms once capacity arrays are stored
// R11 - storage off mode stores nothing
// R12 - absolute style stamps relative to the first stored reading
// R13 - interval style stamps the time since the previous stored reading
// R14 - drop command clears the latched pending input trigger at once
// R15 - host should drop triggers after abort and before first initiate
// R16 - initiate, run-and-fetch and one-shot measure leave idle
// R17 - without auto output-off, initiate needs the output already on
// R18 - one-shot measure turns the output on before initiating
// R19 - auto output-off: on at each cycle start, off after its measurement
// R20 - without auto output-off the output stays on after the run
// R21 - abort or bus clear returns the run to idle
// R22 - an abort leaves the output as it was
// R23 - timestamp reset command and reset zero the absolute timestamp
// R24 - auto timestamp reset zeroes the stamp on leaving idle
// R25 - each run writes from location zero, count rising one per array
`timescale 1ns/100ps
`include "rbrc_regs.svh"
module rbrc_top
    import rbrc_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // reading feeds
    input  wire rbrc_rdg_t   raw_i,
    input  wire rbrc_rdg_t   math_i,
    input  wire rbrc_rdg_t   second_i,
    // measurement engine
    input  wire logic        meas_done_i,
    input  wire logic [11:0] run_ops_i,
    output logic             meas_start_o,
    // trigger pin
    input  wire logic        ext_trig_i,
    // indicators and source
    output logic             src_out_on_o,
    output logic             armed_o,
    output logic             idle_o
);
    // bus handshake
    logic        pend_r;
    logic        acc;
    logic        wr;
    logic        rd;
    logic [31:0] wmask;
    logic [31:0] wd;

    // registers and state
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    logic [11:0] cap_r;
    logic [11:0] count_r;
    logic [11:0] wr_ptr_r;
    logic [11:0] dump_ptr_r;
    logic        refused_r;
    logic        trig_pend_r;
    rbrc_run_t   run_r;
    logic [11:0] ops_r;
    logic [31:0] first_ts_r;
    logic [31:0] prev_ts_r;

    // trigger synchroniser
    logic        trig_s1_r;
    logic        trig_s2_r;
    logic        trig_s3_r;
    logic        trig_flt_r;
    logic        trig_edge;

    // commands
    logic        cmd_wr;
    logic        c_wipe;
    logic        c_drop;
    logic        c_init;
    logic        c_read;
    logic        c_meas;
    logic        c_abort;
    logic        c_busclr;
    logic        c_tsrst;
    logic        c_outon;
    logic        c_outoff;
    logic        c_dump;
    logic        stop;
    logic        go;
    logic        go_req;
    logic        leave_idle;
    logic        consume;
    logic        op_done;

    // storage path
    rbrc_feed_t  feed;
    rbrc_rdg_t   sel_rdg;
    logic        store;
    logic [31:0] ts_now;
    logic [31:0] base_ts;
    rbrc_entry_t wr_entry;
    rbrc_entry_t rd_entry;
    logic [31:0] cap32;
    logic [31:0] free_bytes;
    logic [31:0] rsvd_bytes;
    logic [11:0] cap_wr;
    logic [31:0] rdata;

    // byte lane mask
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign wmask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
        end
    endgenerate

    assign acc = pend_r & ~wb_ack_o;
    assign wr  = acc & wb_we_i;
    assign rd  = acc & ~wb_we_i;
    assign wd  = wb_dat_i & wmask;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pend_r   <= 1'b0;
            wb_ack_o <= 1'b0;
        end else begin
            pend_r   <= wb_cyc_i & wb_stb_i & ~pend_r & ~wb_ack_o;
            wb_ack_o <= acc;
        end
    end

    // command pulses
    assign cmd_wr   = wr && (wb_adr_i == `RBRC_OFS_CMD);
    assign c_wipe   = cmd_wr & wd[`RBRC_CMD_WIPE];
    assign c_drop   = cmd_wr & wd[`RBRC_CMD_DROP];
    assign c_init   = cmd_wr & wd[`RBRC_CMD_INIT];
    assign c_read   = cmd_wr & wd[`RBRC_CMD_READ];
    assign c_meas   = cmd_wr & wd[`RBRC_CMD_MEAS];
    assign c_abort  = cmd_wr & wd[`RBRC_CMD_ABORT];
    assign c_busclr = cmd_wr & wd[`RBRC_CMD_BUSCLR];
    assign c_tsrst  = cmd_wr & wd[`RBRC_CMD_TSRST];
    assign c_outon  = cmd_wr & wd[`RBRC_CMD_OUTON];
    assign c_outoff = cmd_wr & wd[`RBRC_CMD_OUTOFF];
    assign c_dump   = cmd_wr & wd[`RBRC_CMD_DUMP];

    // run start and stop
    assign stop   = c_abort | c_busclr; // R21
    assign go_req = c_init | c_read | c_meas; // R16
    assign go     = (run_r == RBRC_S_IDLE) & ~stop & (c_meas | // R18
                    (go_req & (ctrl_r[`RBRC_CTRL_AUTOOFF] |
                               src_out_on_o))); // R17
    assign leave_idle = go;

    // control register
    always_comb begin
        ctrl_nxt = ((ctrl_r & ~wmask) | wd) & `RBRC_CTRL_MASK;
        if (armed_o) begin
            ctrl_nxt[`RBRC_CTRL_FEED_MSB:`RBRC_CTRL_FEED_LSB] =
                ctrl_r[`RBRC_CTRL_FEED_MSB:`RBRC_CTRL_FEED_LSB]; // R8
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_r <= `RBRC_CTRL_RST;
        end else if (wr && (wb_adr_i == `RBRC_OFS_CTRL)) begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // capacity
    assign cap_wr = wd[11:0];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cap_r <= `RBRC_CAP_RST; // R5
        end else if (wr && (wb_adr_i == `RBRC_OFS_CAP) &&
                     (wd[31:12] == 20'h00000) &&
                     (cap_wr >= `RBRC_CAP_MIN) &&
                     (cap_wr <= `RBRC_CAP_MAX)) begin
            cap_r <= cap_wr; // R5
        end
    end

    // refused initiate or run-and-fetch while idle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            refused_r <= 1'b0;
        end else if (go_req & ~go & (run_r == RBRC_S_IDLE)) begin
            refused_r <= 1'b1;
        end else if (go) begin
            refused_r <= 1'b0;
        end
    end

    // trigger pin synchroniser and filter
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trig_s1_r  <= 1'b0;
            trig_s2_r  <= 1'b0;
            trig_s3_r  <= 1'b0;
            trig_flt_r <= 1'b0;
        end else begin
            trig_s1_r <= ext_trig_i;
            trig_s2_r <= trig_s1_r;
            trig_s3_r <= trig_s2_r;
            if (trig_s2_r == trig_s3_r) begin
                trig_flt_r <= trig_s3_r;
            end
        end
    end

    assign trig_edge = (trig_s2_r == trig_s3_r) & trig_s3_r & ~trig_flt_r;

    // latched input trigger, a new edge wins over a clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trig_pend_r <= 1'b0;
        end else if (trig_edge) begin
            trig_pend_r <= 1'b1;
        end else if (c_drop | consume) begin
            trig_pend_r <= 1'b0; // R14
        end
    end

    // source wait measure sequencer
    assign consume = (run_r == RBRC_S_SRC) & ~stop &
                     (~ctrl_r[`RBRC_CTRL_TRIGWAIT] | trig_pend_r);
    assign op_done = (run_r == RBRC_S_MEAS) & meas_done_i & ~stop;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            run_r <= RBRC_S_IDLE;
            ops_r <= 12'h000;
        end else if (stop) begin
            run_r <= RBRC_S_IDLE; // R21
        end else begin
            unique case (run_r)
                RBRC_S_IDLE: begin
                    if (go) begin
                        run_r <= RBRC_S_SRC; // R16
                        ops_r <= 12'h000;
                    end
                end
                RBRC_S_SRC: begin
                    if (consume) begin
                        run_r <= RBRC_S_MEAS;
                    end
                end
                RBRC_S_MEAS: begin
                    if (op_done) begin
                        ops_r <= ops_r + 12'h001;
                        if (ops_r + 12'h001 >= run_ops_i) begin
                            run_r <= RBRC_S_IDLE;
                        end else begin
                            run_r <= RBRC_S_SRC;
                        end
                    end
                end
                default: begin
                    run_r <= RBRC_S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meas_start_o <= 1'b0;
            idle_o       <= 1'b1;
        end else begin
            meas_start_o <= consume;
            idle_o       <= (run_r == RBRC_S_IDLE) & ~go;
        end
    end

    // source output switch
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            src_out_on_o <= 1'b0;
        end else if (c_meas & go) begin
            src_out_on_o <= 1'b1; // R18
        end else if (stop) begin
            src_out_on_o <= src_out_on_o; // R22
        end else if (ctrl_r[`RBRC_CTRL_AUTOOFF] && op_done) begin
            src_out_on_o <= 1'b0; // R19
        end else if (ctrl_r[`RBRC_CTRL_AUTOOFF] &&
                     (go || (op_done == 1'b0 && consume))) begin
            src_out_on_o <= 1'b1; // R19
        end else if (c_outon) begin
            src_out_on_o <= 1'b1; // R20
        end else if (c_outoff && (run_r == RBRC_S_IDLE)) begin
            src_out_on_o <= 1'b0;
        end
    end

    // feed select
    assign feed = rbrc_feed_t'(
        ctrl_r[`RBRC_CTRL_FEED_MSB:`RBRC_CTRL_FEED_LSB]);

    always_comb begin
        unique case (feed)
            RBRC_FEED_RAW:    sel_rdg = raw_i; // R7
            RBRC_FEED_MATH:   sel_rdg = math_i; // R7
            RBRC_FEED_SECOND: sel_rdg = second_i; // R7
            default:          sel_rdg = raw_i;
        endcase
    end

    assign store = armed_o & ctrl_r[`RBRC_CTRL_FILL] & sel_rdg.valid &
                   (count_r < cap_r) & ~c_wipe; // R11

    // armed indicator
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            armed_o <= 1'b0;
        end else if (leave_idle && ctrl_r[`RBRC_CTRL_FILL]) begin
            armed_o <= 1'b1; // R9
        end else if (stop || !ctrl_r[`RBRC_CTRL_FILL]) begin
            armed_o <= 1'b0; // R11
        end else if (store && (count_r + 12'h001 >= cap_r)) begin
            armed_o <= 1'b0; // R10
        end
    end

    // write pointer and stored count
    always_ff @(posedge clk) begin
        if (sys_rst || c_wipe) begin
            wr_ptr_r <= 12'h000; // R2
            count_r  <= 12'h000; // R2
        end else if (leave_idle && ctrl_r[`RBRC_CTRL_FILL]) begin
            wr_ptr_r <= 12'h000; // R25
            count_r  <= 12'h000; // R3
        end else if (store) begin
            wr_ptr_r <= wr_ptr_r + 12'h001; // R25
            count_r  <= count_r + 12'h001; // R6
        end
    end

    // timestamp reference points
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            first_ts_r <= 32'h00000000;
            prev_ts_r  <= 32'h00000000;
        end else if (store) begin
            if (count_r == 12'h000) begin
                first_ts_r <= ts_now;
            end
            prev_ts_r <= ts_now;
        end
    end

    always_comb begin
        if (count_r == 12'h000) begin
            base_ts = ts_now;
        end else if (ctrl_r[`RBRC_CTRL_STYLE]) begin
            base_ts = prev_ts_r; // R13
        end else begin
            base_ts = first_ts_r; // R12
        end
    end

    assign wr_entry.value = sel_rdg.value;
    assign wr_entry.stamp = ts_now - base_ts;

    rbrc_tstamp u_tstamp (
        .clk     (clk),
        .sys_rst (sys_rst),
        .zero_i  (c_tsrst | (leave_idle & ctrl_r[`RBRC_CTRL_ATSR])), // R24
        .stamp_o (ts_now)
    ); // R23

    rbrc_store u_store (
        .clk     (clk),
        .wr_en   (store),
        .wr_addr (wr_ptr_r),
        .wr_data (wr_entry),
        .rd_addr (dump_ptr_r),
        .rd_data (rd_entry)
    );

    // dump pointer, advanced by each stamp read
    always_ff @(posedge clk) begin
        if (sys_rst || c_wipe || c_dump) begin
            dump_ptr_r <= 12'h000; // R1
        end else if (rd && (wb_adr_i == `RBRC_OFS_DUMPT) &&
                     (dump_ptr_r < count_r)) begin
            dump_ptr_r <= dump_ptr_r + 12'h001; // R1
        end
    end

    // memory usage
    assign cap32      = {20'h00000, cap_r};
    assign rsvd_bytes = cap32 << `RBRC_BYTES_SHIFT; // R4
    assign free_bytes = ({20'h00000, `RBRC_CAP_MAX} - cap32)
                        << `RBRC_BYTES_SHIFT; // R4

    // read mux
    always_comb begin
        rdata = 32'h00000000;
        unique case (wb_adr_i)
            `RBRC_OFS_CTRL:  rdata = ctrl_r;
            `RBRC_OFS_CAP:   rdata = cap32;
            `RBRC_OFS_COUNT: rdata = {20'h00000, count_r}; // R6
            `RBRC_OFS_FREE:  rdata = free_bytes;
            `RBRC_OFS_RSVD:  rdata = rsvd_bytes;
            `RBRC_OFS_STAT: begin
                rdata[`RBRC_STAT_IDLE]    = (run_r == RBRC_S_IDLE);
                rdata[`RBRC_STAT_ARMED]   = armed_o;
                rdata[`RBRC_STAT_OUTON]   = src_out_on_o;
                rdata[`RBRC_STAT_PEND]    = trig_pend_r;
                rdata[`RBRC_STAT_REFUSED] = refused_r;
            end
            `RBRC_OFS_DUMPV: begin
                if (dump_ptr_r < count_r) begin
                    rdata = rd_entry.value; // R1
                end
            end
            `RBRC_OFS_DUMPT: begin
                if (dump_ptr_r < count_r) begin
                    rdata = rd_entry.stamp; // R1
                end
            end
            default: rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wb_dat_o <= 32'h00000000;
        end else if (rd) begin
            wb_dat_o <= rdata;
        end
    end
endmodule : rbrc_top

//--- tb/rbrc_props.sv
// port checks for rbrc_top
// assumes a bind to rbrc_top
`timescale 1ns/100ps
`include "rbrc_regs.svh"
module rbrc_props
    import rbrc_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    // run
    input wire logic        meas_start_o,
    input wire logic        src_out_on_o,
    input wire logic        armed_o,
    input wire logic        idle_o
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    wire cmd = wb_ack_o && wb_we_i && wb_adr_i == `RBRC_OFS_CMD;
    wire abt = cmd && wb_dat_i[`RBRC_CMD_ABORT];
    wire clr = cmd && wb_dat_i[`RBRC_CMD_BUSCLR];
    wire mea = cmd && wb_dat_i[`RBRC_CMD_MEAS];

    property p_ack_one;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack too long");
    property p_ack_time;
        $rose(wb_stb_i) && wb_cyc_i |-> !wb_ack_o ##2 wb_ack_o;
    endproperty
    a_ack_time: assert property (p_ack_time) else $error("ack late");
    property p_abort;
        abt |-> ##[0:1] idle_o;
    endproperty
    a_abort: assert property (p_abort) else $error("abort");
    property p_busclr;
        clr |-> ##[0:1] idle_o;
    endproperty
    a_busclr: assert property (p_busclr) else $error("bus clear");
    property p_keep;
        abt |-> src_out_on_o == $past(src_out_on_o);
    endproperty
    a_keep: assert property (p_keep) else $error("output moved");
    property p_meas;
        mea && $past(idle_o) |-> ##[0:1] (src_out_on_o && !idle_o);
    endproperty
    a_meas: assert property (p_meas) else $error("measure");
    property p_start;
        meas_start_o |-> !idle_o;
    endproperty
    a_start: assert property (p_start) else $error("start idle");
    property p_arm;
        $rose(armed_o) |-> ##[0:1] !idle_o;
    endproperty
    a_arm: assert property (p_arm) else $error("arm");
    c_abort: cover property (abt);
    c_arm_end: cover property ($fell(armed_o));
    c_meas: cover property (meas_start_o);
endmodule : rbrc_props

bind rbrc_top rbrc_props props (
    .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .meas_start_o(meas_start_o), .src_out_on_o(src_out_on_o),
    .armed_o(armed_o), .idle_o(idle_o)
);

//--- tb/rbrc_engine.sv
// measurement engine model
// assumes one start pulse per measurement
`timescale 1ns/100ps
module rbrc_engine
    import rbrc_pkg::*;
(
    // clock and pacing
    input  wire logic       clk,
    input  wire logic       start,
    input  wire logic [7:0] delay,
    // results
    output logic            done,
    output rbrc_rdg_t       raw,
    output rbrc_rdg_t       math,
    output rbrc_rdg_t       second
);
    logic [7:0]  wait_r = 8'h00;
    logic        busy_r = 1'b0;
    logic [23:0] seq_r = 24'h000001;

    // idle feeds carry a moving pattern
    always @(posedge clk) begin
        done <= 1'b0;
        raw <= {1'b0, wait_r, ~seq_r};
        math <= {1'b0, ~wait_r, seq_r};
        second <= {1'b0, wait_r, seq_r};
        if (start) begin
            busy_r <= 1'b1;
            wait_r <= delay;
        end else if (busy_r && wait_r != 8'h00) begin
            wait_r <= wait_r - 8'h01;
        end else if (busy_r) begin
            busy_r <= 1'b0;
            done <= 1'b1;
            raw <= {1'b1, 8'h0a, seq_r};
            math <= {1'b1, 8'h0b, seq_r};
            second <= {1'b1, 8'h0c, seq_r};
            seq_r <= seq_r + 24'h000001;
        end
    end
endmodule : rbrc_engine

//--- tb/rbrc_top_bench.sv
// self-checking bench for rbrc_top
// assumes the engine model paces measurements
`timescale 1ns/100ps
`include "rbrc_regs.svh"
module rbrc_top_bench
    import rbrc_pkg::*;
;
    logic        clk, sys_rst, cyc, stb, we, ack, done, ms;
    logic        trig, out_on, armed, idle;
    logic [7:0]  adr, dly;
    logic [11:0] ops;
    logic [31:0] dat, rdat, rd, c, e, st[3];
    rbrc_rdg_t   raw, math, second;
    int          error_cnt = 0, check_count = 0, ticks = 0, seq = 0, s0;
    logic [31:0] cv[4] = '{32'h0, 32'h9c5, 32'h1, 32'h9c4};
    logic [31:0] ce[4] = '{32'h64, 32'h64, 32'h1, 32'h9c4};
    logic [31:0] sc[3] = '{32'h4, 32'h8, 32'h10};
    logic [31:0] ab[3] = '{32'h20, 32'h40, 32'h20};

    rbrc_top uut (
        .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .raw_i(raw), .math_i(math),
        .second_i(second), .meas_done_i(done), .run_ops_i(ops),
        .meas_start_o(ms), .ext_trig_i(trig), .src_out_on_o(out_on),
        .armed_o(armed), .idle_o(idle)
    );
    rbrc_engine eng (
        .clk(clk), .start(ms), .delay(dly), .done(done), .raw(raw),
        .math(math), .second(second)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        ticks <= ticks + 1;
        if (done === 1'b1)
            seq <= seq + 1;
        if (ticks == 30000) begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d bad %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    task automatic chk(string nm, logic [31:0] ex, logic [31:0] g);
        check_count++;
        if (g !== ex) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, ex, g);
        end
    endtask : chk

    task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do
            @(posedge clk);
        while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : xfer

    task automatic cmd(logic [31:0] d);
        xfer(1'b1, `RBRC_OFS_CMD, d);
    endtask : cmd

    task automatic rchk(logic [7:0] a, logic [31:0] ex, string nm);
        xfer(1'b0, a, 32'h0);
        chk(nm, ex, rd);
    endtask : rchk

    initial begin
        sys_rst = 1'b1;
        {cyc, stb, we, trig, adr, dat} = '0;
        ops = 12'h005;
        dly = 8'h02;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rchk(`RBRC_OFS_CAP, 32'h64, "cap");
        rchk(`RBRC_OFS_FREE, 32'h4b00, "free");
        rchk(`RBRC_OFS_RSVD, 32'h320, "rsvd");
        rchk(`RBRC_OFS_COUNT, 32'h0, "count");
        rchk(8'h40, 32'h0, "unmapped");
        cmd(32'h2);
        foreach (cv[i]) begin
            xfer(1, `RBRC_OFS_CAP, cv[i]);
            rchk(`RBRC_OFS_CAP, ce[i], "cap");
        end
        rchk(`RBRC_OFS_FREE, 32'h0, "free");
        rchk(`RBRC_OFS_RSVD, 32'h4e20, "rsvd");
        xfer(1, `RBRC_OFS_CTRL, 32'h4);
        cmd(32'h4);
        rchk(`RBRC_OFS_STAT, 32'h11, "refused");
        $display("regs done");
        xfer(1, `RBRC_OFS_CAP, 32'h3);
        cmd(32'h100);
        dly <= 8'hfa;
        for (int f = 0; f < 3; f++) begin
            c = {28'h0, f == 1, 1'b1, 2'(f)};
            xfer(1, `RBRC_OFS_CTRL, c);
            s0 = seq;
            cmd(32'h4);
            chk("armed", 32'h1, 32'(armed));
            xfer(1, `RBRC_OFS_CTRL, c ^ 32'h2);
            rchk(`RBRC_OFS_CTRL, c, "ctrl");
            wait (idle === 1'b1);
            chk("armed", 32'h0, 32'(armed));
            chk("out", 32'h1, 32'(out_on));
            rchk(`RBRC_OFS_COUNT, 32'h3, "count");
            cmd(32'h400);
            for (int k = 0; k < 3; k++) begin
                e = {8'h0a + 8'(f), 24'(s0 + k + 1)};
                rchk(`RBRC_OFS_DUMPV, e, "value");
                xfer(1'b0, `RBRC_OFS_DUMPT, 32'h0);
                st[k] = rd;
            end
            rchk(`RBRC_OFS_DUMPV, 32'h0, "end");
            chk("stamp0", 32'h0, st[0]);
            if (f == 1)
                chk("delta", 32'h1, 32'(st[2] <= 32'h3));
            else
                chk("abs", 32'h1, 32'(st[2] >= 32'h4));
        end
        $display("store done");
        cmd(32'h1);
        rchk(`RBRC_OFS_COUNT, 32'h0, "count");
        rchk(`RBRC_OFS_DUMPV, 32'h0, "value");
        dly <= 8'h02;
        xfer(1, `RBRC_OFS_CTRL, 32'h0);
        cmd(32'h4);
        wait (idle === 1'b1);
        rchk(`RBRC_OFS_COUNT, 32'h0, "count");
        foreach (sc[i]) begin
            cmd(sc[i]);
            chk("run", 32'h0, 32'(idle));
            cmd(ab[i]);
            chk("idle", 32'h1, 32'(idle));
        end
        cmd(32'h200);
        cmd(32'h10);
        chk("out", 32'h1, 32'(out_on));
        wait (idle === 1'b1);
        $display("start done");
        dly <= 8'h14;
        xfer(1, `RBRC_OFS_CTRL, 32'h10);
        cmd(32'h200);
        ops <= 12'h001;
        cmd(32'h4);
        chk("run", 32'h0, 32'(idle));
        wait (ms === 1'b1);
        chk("out", 32'h1, 32'(out_on));
        wait (idle === 1'b1);
        chk("out", 32'h0, 32'(out_on));
        ops <= 12'h005;
        cmd(32'h4);
        wait (ms === 1'b1);
        cmd(32'h20);
        chk("idle", 32'h1, 32'(idle));
        chk("out", 32'h1, 32'(out_on));
        xfer(1, `RBRC_OFS_CTRL, 32'h40);
        trig <= 1'b1;
        repeat (8) @(posedge clk);
        trig <= 1'b0;
        rchk(`RBRC_OFS_STAT, 32'hd, "pending");
        cmd(32'h2);
        rchk(`RBRC_OFS_STAT, 32'h5, "pending");
        $display("output done");
        give_verdict();
    end
endmodule : rbrc_top_bench
